// file: design/sfe_pkg.sv
// Purpose: Constants and types for the serial message front end.
// Assumes: 25 MHz system clock; 7 data bits, odd parity, one stop bit.
// Notes: Register offsets are byte addresses on the plain register port.
package sfe_pkg;

  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 57_600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam logic [8:0] BIT_LAST = 9'(BIT_CYC - 1);
  localparam logic [8:0] HALF_LAST = 9'(BIT_CYC / 2 - 1);
  localparam logic [3:0] RX_STOP_IDX = 4'h8;
  localparam logic [3:0] TX_LAST_IDX = 4'h9;

  // Message limits and characters
  localparam int MSG_MAX = 255;
  localparam logic [7:0] MAX_LEN = 8'(MSG_MAX - 1);
  localparam logic [6:0] CH_LF = 7'h0a;
  localparam logic [6:0] CH_SEMI = 7'h3b;
  localparam logic [6:0] CH_QMARK = 7'h3f;
  localparam logic [6:0] CH_SPACE = 7'h20;
  localparam logic [6:0] CH_STAR = 7'h2a;

  // Register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_INFO = 4'hc;

  // Status bit positions
  localparam int ST_MSG = 0;
  localparam int ST_PAR = 1;
  localparam int ST_FRM = 2;
  localparam int ST_OVF = 3;
  localparam int ST_RSP = 4;
  localparam int ST_W = 5;

  // Reset values
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  localparam logic CTRL_RX_EN_RST = 1'b1;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    SFE_RX_IDLE = 2'b00,
    SFE_RX_START = 2'b01,
    SFE_RX_BITS = 2'b10
  } sfe_rx_st_t;

  typedef enum logic [0:0] {
    SFE_DP_IDLE = 1'b0,
    SFE_DP_RUN = 1'b1
  } sfe_dp_st_t;

  typedef enum logic [0:0] {
    SFE_TX_IDLE = 1'b0,
    SFE_TX_SHIFT = 1'b1
  } sfe_tx_st_t;

  // Parsed character stream toward the command handler
  typedef struct packed {
    logic valid;
    logic [6:0] ch;
    logic seg_end;
    logic is_query;
    logic is_common;
  } sfe_cmd_t;

  // Response characters from the command handler
  typedef struct packed {
    logic valid;
    logic [6:0] data;
    logic last;
  } sfe_rsp_t;

endpackage : sfe_pkg

// file: design/sfe_core.sv
// Purpose: Serial message front end: receiver, framer, splitter, responder.
// Assumes: serial_rx synchronous to clk_sys; handler honours rsp_ready.
// Notes: Messages are held until the terminator so bad ones never reach the handler.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
module sfe_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial line
  input wire logic serial_rx,
  output logic serial_tx,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Command handler
  output sfe_pkg::sfe_cmd_t cmd_stream,
  input wire sfe_pkg::sfe_rsp_t rsp_char,
  output logic rsp_ready,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    sfe_pkg::sfe_rx_st_t rx_st;
    logic [8:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [sfe_pkg::MSG_MAX-1:0][6:0] mem;
    logic [7:0] wr_len;
    logic msg_bad;
    sfe_pkg::sfe_dp_st_t dp_st;
    logic [7:0] dp_len;
    logic [7:0] rd_idx;
    logic [7:0] seg_len;
    logic seg_q;
    logic seg_sp;
    logic seg_star;
    sfe_pkg::sfe_cmd_t cmd;
    sfe_pkg::sfe_tx_st_t tx_st;
    logic [8:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
    logic lf_pend;
    logic [7:0] q_cnt;
    logic [sfe_pkg::ST_W-1:0] status;
    logic [sfe_pkg::ST_W-1:0] mask;
    logic rx_en;
    logic [7:0] last_len;
    logic [31:0] rdata;
  } sfe_state_t;

  sfe_state_t s_q;
  sfe_state_t s_d;

  logic rx_tick;
  logic rx_done;
  logic [6:0] rx_char;
  logic rx_perr;
  logic rx_ferr;
  logic rsp_take;
  logic lf_go;
  logic [6:0] dp_ch;

  // Ten-bit frame, sent LSB first: start, data, odd parity, stop
  function automatic logic [9:0] sfe_frame(input logic [6:0] d);
    sfe_frame = {1'b1, ~^d, d, 1'b0};
  endfunction : sfe_frame

  // Receiver and transmitter observations
  assign rx_tick = (s_q.rx_st == sfe_pkg::SFE_RX_BITS) && (s_q.rx_cnt == sfe_pkg::BIT_LAST);
  assign rx_done = rx_tick && (s_q.rx_bit == sfe_pkg::RX_STOP_IDX);
  assign rx_char = s_q.rx_sh[6:0];
  assign rx_perr = ~^s_q.rx_sh;
  assign rx_ferr = !serial_rx;
  assign rsp_ready = (s_q.tx_st == sfe_pkg::SFE_TX_IDLE) && !s_q.lf_pend
    && (s_q.q_cnt != 8'h00);
  assign rsp_take = rsp_ready && rsp_char.valid;
  assign lf_go = (s_q.tx_st == sfe_pkg::SFE_TX_IDLE) && s_q.lf_pend;
  assign dp_ch = s_q.mem[s_q.rd_idx];

  // Outputs from state
  assign serial_tx = s_q.tx_line;
  assign cmd_stream = s_q.cmd;
  assign reg_rdata = s_q.rdata;
  assign irq = |(s_q.status & s_q.mask);

  // Next-state logic
  always_comb begin
    logic [sfe_pkg::ST_W-1:0] set;
    logic [sfe_pkg::ST_W-1:0] clr;
    logic q_inc;
    logic q_dec;
    set = '0;
    clr = '0;
    q_inc = 1'b0;
    q_dec = 1'b0;
    s_d = s_q;
    s_d.cmd = '0;
    s_d.rdata = '0;

    // Receiver bit timing, sampling mid-bit
    case (s_q.rx_st)
      sfe_pkg::SFE_RX_IDLE: begin
        if (s_q.rx_en && !serial_rx) begin
          s_d.rx_st = sfe_pkg::SFE_RX_START;
          s_d.rx_cnt = '0;
        end
      end
      sfe_pkg::SFE_RX_START: begin
        s_d.rx_cnt = s_q.rx_cnt + 9'h001;
        if (s_q.rx_cnt == sfe_pkg::HALF_LAST) begin
          s_d.rx_cnt = '0;
          s_d.rx_bit = '0;
          s_d.rx_st = serial_rx ? sfe_pkg::SFE_RX_IDLE : sfe_pkg::SFE_RX_BITS;
        end
      end
      sfe_pkg::SFE_RX_BITS: begin
        s_d.rx_cnt = s_q.rx_cnt + 9'h001;
        if (rx_tick) begin
          s_d.rx_cnt = '0;
          s_d.rx_bit = s_q.rx_bit + 4'h1;
          if (rx_done) begin
            s_d.rx_st = sfe_pkg::SFE_RX_IDLE;
          end else begin
            s_d.rx_sh = {serial_rx, s_q.rx_sh[7:1]};
          end
        end
      end
      default: begin
        s_d.rx_st = sfe_pkg::SFE_RX_IDLE;
      end
    endcase

    // Splitter: replay a good message, one character a cycle
    if (s_q.dp_st == sfe_pkg::SFE_DP_RUN) begin
      if (s_q.rd_idx == s_q.dp_len) begin
        if (s_q.seg_len != 8'h00) begin
          s_d.cmd.seg_end = 1'b1;
          s_d.cmd.is_query = s_q.seg_q;
          s_d.cmd.is_common = s_q.seg_star;
          q_inc = s_q.seg_q;
        end
        s_d.dp_st = sfe_pkg::SFE_DP_IDLE;
      end else begin
        s_d.rd_idx = s_q.rd_idx + 8'h01;
        if (dp_ch == sfe_pkg::CH_SEMI) begin
          if (s_q.seg_len != 8'h00) begin
            s_d.cmd.seg_end = 1'b1;
            s_d.cmd.is_query = s_q.seg_q;
            s_d.cmd.is_common = s_q.seg_star;
            q_inc = s_q.seg_q;
          end
          s_d.seg_len = '0;
          s_d.seg_q = 1'b0;
          s_d.seg_sp = 1'b0;
          s_d.seg_star = 1'b0;
        end else begin
          s_d.cmd.valid = 1'b1;
          s_d.cmd.ch = dp_ch;
          s_d.seg_len = s_q.seg_len + 8'h01;
          if (s_q.seg_len == 8'h00 && dp_ch == sfe_pkg::CH_STAR) begin
            s_d.seg_star = 1'b1;
          end
          // Question mark counts only within the mnemonic
          if (!s_q.seg_sp && dp_ch == sfe_pkg::CH_SPACE) begin
            s_d.seg_sp = 1'b1;
          end else if (!s_q.seg_sp && dp_ch == sfe_pkg::CH_QMARK) begin
            s_d.seg_q = 1'b1;
          end
        end
      end
    end

    // Character handling: store, end of message, errors, overflow
    if (rx_done) begin
      set[sfe_pkg::ST_PAR] = rx_perr;
      set[sfe_pkg::ST_FRM] = rx_ferr;
      if (rx_char == sfe_pkg::CH_LF) begin
        if (!s_q.msg_bad && !rx_perr && !rx_ferr && s_q.dp_st == sfe_pkg::SFE_DP_IDLE) begin
          s_d.dp_st = sfe_pkg::SFE_DP_RUN;
          s_d.dp_len = s_q.wr_len;
          s_d.rd_idx = '0;
          s_d.seg_len = '0;
          s_d.seg_q = 1'b0;
          s_d.seg_sp = 1'b0;
          s_d.seg_star = 1'b0;
          s_d.last_len = s_q.wr_len;
          set[sfe_pkg::ST_MSG] = 1'b1;
        end
        s_d.wr_len = '0;
        s_d.msg_bad = 1'b0;
      end else if (rx_perr || rx_ferr) begin
        s_d.msg_bad = 1'b1;
      end else if (s_q.wr_len == sfe_pkg::MAX_LEN) begin
        set[sfe_pkg::ST_OVF] = !s_q.msg_bad;
        s_d.msg_bad = 1'b1;
      end else begin
        s_d.mem[s_q.wr_len] = rx_char;
        s_d.wr_len = s_q.wr_len + 8'h01;
      end
    end

    // Transmitter: response characters, then the terminator
    case (s_q.tx_st)
      sfe_pkg::SFE_TX_IDLE: begin
        if (rsp_take) begin
          s_d.tx_sh = sfe_frame(rsp_char.data);
          s_d.tx_st = sfe_pkg::SFE_TX_SHIFT;
          s_d.tx_cnt = '0;
          s_d.tx_bit = '0;
          s_d.lf_pend = rsp_char.last;
        end else if (lf_go) begin
          s_d.tx_sh = sfe_frame(sfe_pkg::CH_LF);
          s_d.tx_st = sfe_pkg::SFE_TX_SHIFT;
          s_d.tx_cnt = '0;
          s_d.tx_bit = '0;
          s_d.lf_pend = 1'b0;
          q_dec = 1'b1;
          set[sfe_pkg::ST_RSP] = 1'b1;
        end
      end
      sfe_pkg::SFE_TX_SHIFT: begin
        s_d.tx_cnt = s_q.tx_cnt + 9'h001;
        if (s_q.tx_cnt == sfe_pkg::BIT_LAST) begin
          s_d.tx_cnt = '0;
          s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
          s_d.tx_bit = s_q.tx_bit + 4'h1;
          if (s_q.tx_bit == sfe_pkg::TX_LAST_IDX) begin
            s_d.tx_st = sfe_pkg::SFE_TX_IDLE;
          end
        end
      end
      default: begin
        s_d.tx_st = sfe_pkg::SFE_TX_IDLE;
      end
    endcase
    s_d.tx_line = (s_d.tx_st == sfe_pkg::SFE_TX_SHIFT) ? s_d.tx_sh[0] : sfe_pkg::LINE_IDLE;
    s_d.q_cnt = s_q.q_cnt + {7'h00, q_inc} - {7'h00, q_dec};

    // Register writes; status clears by writing ones, a new event wins
    if (reg_wr) begin
      if (reg_addr == sfe_pkg::ADDR_STATUS) begin
        clr = reg_wdata[sfe_pkg::ST_W-1:0];
      end else if (reg_addr == sfe_pkg::ADDR_MASK) begin
        s_d.mask = reg_wdata[sfe_pkg::ST_W-1:0];
      end else if (reg_addr == sfe_pkg::ADDR_CTRL) begin
        s_d.rx_en = reg_wdata[0];
      end
    end
    s_d.status = (s_q.status & ~clr) | set;

    // Register reads, data in the following cycle
    if (reg_rd) begin
      if (reg_addr == sfe_pkg::ADDR_STATUS) begin
        s_d.rdata = {27'h0000000, s_q.status};
      end else if (reg_addr == sfe_pkg::ADDR_MASK) begin
        s_d.rdata = {27'h0000000, s_q.mask};
      end else if (reg_addr == sfe_pkg::ADDR_CTRL) begin
        s_d.rdata = {31'h00000000, s_q.rx_en};
      end else if (reg_addr == sfe_pkg::ADDR_INFO) begin
        s_d.rdata = {16'h0000, s_q.last_len, s_q.q_cnt};
      end else begin
        s_d.rdata = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.tx_line <= sfe_pkg::LINE_IDLE;
      s_q.rx_en <= sfe_pkg::CTRL_RX_EN_RST;
      s_q.mask <= sfe_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence tx_frame_start_s;
    s_q.tx_st == sfe_pkg::SFE_TX_IDLE ##1 s_q.tx_st == sfe_pkg::SFE_TX_SHIFT;
  endsequence

  sequence tx_frame_end_s;
    s_q.tx_st == sfe_pkg::SFE_TX_SHIFT && s_q.tx_cnt == sfe_pkg::BIT_LAST
      && s_q.tx_bit == sfe_pkg::TX_LAST_IDX;
  endsequence

  tx_start_bit_a: assert property (tx_frame_start_s |-> !serial_tx [*8])
    else $error("start bit not held low");
  tx_bit_hold_a: assert property ((s_q.tx_st == sfe_pkg::SFE_TX_SHIFT
    && s_q.tx_cnt != sfe_pkg::BIT_LAST) |=> $stable(serial_tx))
    else $error("tx line moved inside a bit");
  tx_stop_end_a: assert property (tx_frame_end_s |=> serial_tx
    && s_q.tx_st == sfe_pkg::SFE_TX_IDLE)
    else $error("frame did not end after ten bits");
  tx_parity_odd_a: assert property ((rsp_take || lf_go) |=> ^s_q.tx_sh[8:1])
    else $error("transmit parity not odd");
  lf_dispatch_a: assert property ((rx_done && rx_char == sfe_pkg::CH_LF && !s_q.msg_bad
    && !rx_perr && !rx_ferr && s_q.dp_st == sfe_pkg::SFE_DP_IDLE)
    |=> s_q.dp_st == sfe_pkg::SFE_DP_RUN && s_q.wr_len == 8'h00)
    else $error("terminator did not start dispatch");
  semi_split_a: assert property ((s_q.dp_st == sfe_pkg::SFE_DP_RUN
    && s_q.rd_idx != s_q.dp_len && dp_ch == sfe_pkg::CH_SEMI && s_q.seg_len != 8'h00)
    |=> cmd_stream.seg_end && !cmd_stream.valid)
    else $error("semicolon did not end a segment");
  query_owed_a: assert property ((cmd_stream.seg_end && cmd_stream.is_query)
    |-> s_q.q_cnt != 8'h00 ##1 rsp_ready || s_q.tx_st == sfe_pkg::SFE_TX_SHIFT
    || s_q.lf_pend)
    else $error("query not owed a response");
  silent_tx_a: assert property ((s_q.tx_st == sfe_pkg::SFE_TX_IDLE && !s_q.lf_pend
    && s_q.q_cnt == 8'h00) |=> s_q.tx_st == sfe_pkg::SFE_TX_IDLE && serial_tx)
    else $error("transmission without a query");
  resp_term_a: assert property ((rsp_take && rsp_char.last) |=> s_q.lf_pend
    && s_q.tx_st == sfe_pkg::SFE_TX_SHIFT)
    else $error("response not followed by terminator");
  // The frame is far longer than a delay range, so the hand-over is checked at its end
  term_follow_a: assert property ((tx_frame_end_s ##0 s_q.lf_pend) |=> lf_go)
    else $error("terminator did not follow response");
  err_drop_a: assert property ((rx_done && (rx_perr || rx_ferr) && rx_char != sfe_pkg::CH_LF)
    |=> s_q.msg_bad && s_q.status[sfe_pkg::ST_PAR] | s_q.status[sfe_pkg::ST_FRM])
    else $error("bad character did not poison message");
  ovf_drop_a: assert property ((rx_done && !rx_perr && !rx_ferr && rx_char != sfe_pkg::CH_LF
    && s_q.wr_len == sfe_pkg::MAX_LEN) |=> s_q.msg_bad && s_q.wr_len == sfe_pkg::MAX_LEN)
    else $error("overlong message not dropped");

  // Dispatch start and the forwarded character stream
  sequence dp_start_s;
    s_q.dp_st == sfe_pkg::SFE_DP_IDLE ##1 s_q.dp_st == sfe_pkg::SFE_DP_RUN;
  endsequence

  dispatch_msg_a: assert property (dp_start_s |-> s_q.status[sfe_pkg::ST_MSG])
    else $error("dispatch without message status");
  char_forward_a: assert property ((s_q.dp_st == sfe_pkg::SFE_DP_RUN
    && s_q.rd_idx != s_q.dp_len && dp_ch != sfe_pkg::CH_SEMI)
    |=> cmd_stream.valid && cmd_stream.ch == $past(dp_ch))
    else $error("stored character not forwarded");
  delim_drop_a: assert property (cmd_stream.valid |-> cmd_stream.ch != sfe_pkg::CH_SEMI
    && cmd_stream.ch != sfe_pkg::CH_LF)
    else $error("separator or terminator forwarded");

endmodule : sfe_core

// file: tb/sfe_host_model.sv
// Purpose: Host program model on the serial line of the front end.
// Assumes: Seven data bits, odd parity, one stop bit at the package bit period.
// Notes: Bad parity or stop bits only when the bench asks for them.
`timescale 1ns/1ps
module sfe_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial line
  input wire logic serial_tx,
  output logic serial_rx
);
  logic [6:0] rx_q[$];
  logic [8:0] rx_bits;
  int rx_bad = 0;

  initial serial_rx = sfe_pkg::LINE_IDLE;

  // Sends one frame: start, data LSB first, parity, stop
  task automatic send_char(input logic [6:0] ch, input logic bad_par, input logic bad_stop);
    logic [9:0] frm;
    frm = {~bad_stop, ~(^ch) ^ bad_par, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      serial_rx <= frm[i];
      repeat (sfe_pkg::BIT_CYC - 1) @(posedge clk_sys);
    end
    // Idle gap so the next start bit has a falling edge
    if (bad_stop) begin
      @(posedge clk_sys);
      serial_rx <= 1'b1;
      repeat (sfe_pkg::BIT_CYC - 1) @(posedge clk_sys);
    end
  endtask : send_char

  // Sends a whole string without pauses; bench strings stay far below the limit
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(7'(s[i]), 1'b0, 1'b0);
    end
  endtask : send_str

  // Takes in every response frame through its terminator
  initial forever begin
    @(negedge clk_sys);
    if (serial_tx === 1'b0) begin
      repeat (sfe_pkg::BIT_CYC / 2) @(negedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (sfe_pkg::BIT_CYC) @(negedge clk_sys);
        rx_bits[i] = serial_tx;
      end
      if (^rx_bits[7:0] !== 1'b1 || rx_bits[8] !== 1'b1) begin
        rx_bad++;
      end
      rx_q.push_back(rx_bits[6:0]);
    end
  end
endmodule : sfe_host_model

// file: tb/test_serial_message_front_end.sv
// Purpose: Self-checking bench for the serial message front end.
// Assumes: Host model on the serial line, bench acts as command handler.
// Notes: Holds a reply offer from time zero so early transmission shows.
`timescale 1ns/1ps
module test_serial_message_front_end;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic serial_rx;
  logic serial_tx;
  logic rsp_ready;
  logic irq;
  logic rsp_v = 1'b1;
  sfe_pkg::sfe_cmd_t cmd_stream;
  sfe_pkg::sfe_rsp_t rsp_char;
  logic [6:0] cmd_q[$];
  logic [1:0] seg_q[$];
  int num_errors = 0;
  int compares = 0;

  assign rsp_char = {rsp_v, 7'h52, 1'b1};

  always #20 clk_sys = ~clk_sys;

  sfe_core i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_stream(cmd_stream), .rsp_char(rsp_char),
    .rsp_ready(rsp_ready), .irq(irq)
  );

  sfe_host_model i_host (.clk_sys(clk_sys), .serial_tx(serial_tx), .serial_rx(serial_rx));

  // Handler side: one reply character, withdrawn once taken
  always @(posedge clk_sys) begin
    if (rsp_v && rsp_ready === 1'b1) begin
      rsp_v <= 1'b0;
    end
  end

  // Collects the parsed stream
  always @(posedge clk_sys) begin
    if (cmd_stream.valid === 1'b1) begin
      cmd_q.push_back(cmd_stream.ch);
    end
    if (cmd_stream.seg_end === 1'b1) begin
      seg_q.push_back({cmd_stream.is_query, cmd_stream.is_common});
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask : reg_chk

  task automatic wait_rx(input int n);
    int k;
    for (k = 0; k < 20000 && i_host.rx_q.size() < n; k++) begin
      @(posedge clk_sys);
    end
    if (k == 20000) begin
      num_errors++;
      $display("[ERR] rx frames expected %0d seen %0d", n, i_host.rx_q.size());
      test_done();
    end
  endtask : wait_rx

  initial begin
    string exp_s;
    exp_s = "*Q?B 1";
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, unmapped place, field widths
    reg_chk("status", sfe_pkg::ADDR_STATUS, 32'h0);
    reg_chk("mask", sfe_pkg::ADDR_MASK, 32'h0);
    reg_chk("ctrl", sfe_pkg::ADDR_CTRL, 32'h1);
    reg_chk("info", sfe_pkg::ADDR_INFO, 32'h0);
    reg_chk("unmapped", 4'h2, 32'h0);
    reg_write(sfe_pkg::ADDR_MASK, 32'hffffffff);
    reg_chk("mask rw", sfe_pkg::ADDR_MASK, 32'h1f);
    reg_write(sfe_pkg::ADDR_CTRL, 32'hffffffff);
    reg_chk("ctrl rw", sfe_pkg::ADDR_CTRL, 32'h1);
    chk("irq idle", irq, 32'h0);
    chk("ready idle", rsp_ready, 32'h0);
    $display("test registers done");
    // Bad parity, then bad stop, each message closed by a terminator
    i_host.send_char(7'h58, 1'b1, 1'b0);
    i_host.send_char(sfe_pkg::CH_LF, 1'b0, 1'b0);
    i_host.send_char(7'h59, 1'b0, 1'b1);
    i_host.send_char(sfe_pkg::CH_LF, 1'b0, 1'b0);
    // Inter-message gaps are scaled down; the block does not time them
    repeat (4) @(posedge clk_sys);
    reg_chk("status err", sfe_pkg::ADDR_STATUS, 32'h06);
    chk("irq err", irq, 32'h1);
    chk("cmd dropped", cmd_q.size(), 32'h0);
    chk("tx silent", i_host.rx_q.size(), 32'h0);
    reg_write(sfe_pkg::ADDR_STATUS, 32'h06);
    reg_chk("status clr", sfe_pkg::ADDR_STATUS, 32'h0);
    chk("irq clr", irq, 32'h0);
    // Receiver off: a lone terminator must not end a message
    reg_write(sfe_pkg::ADDR_CTRL, 32'h0);
    i_host.send_char(sfe_pkg::CH_LF, 1'b0, 1'b0);
    reg_write(sfe_pkg::ADDR_CTRL, 32'h1);
    reg_chk("status rx off", sfe_pkg::ADDR_STATUS, 32'h0);
    chk("cmd rx off", cmd_q.size(), 32'h0);
    $display("test errors done");
    // Common query chained with an empty part and a command
    i_host.send_str("*Q?;;B 1");
    chk("tx before lf", i_host.rx_q.size(), 32'h0);
    i_host.send_char(sfe_pkg::CH_LF, 1'b0, 1'b0);
    #1;
    chk("tx started", serial_tx, 32'h0);
    repeat (20) @(posedge clk_sys);
    chk("cmd count", cmd_q.size(), 32'h6);
    chk("ready busy", rsp_ready, 32'h0);
    for (int i = 0; i < 6; i++) begin
      chk("cmd ch", cmd_q[i], 32'(exp_s[i]));
    end
    chk("seg count", seg_q.size(), 32'h2);
    chk("seg kinds", {seg_q[0], seg_q[1]}, 32'hc);
    reg_chk("status msg", sfe_pkg::ADDR_STATUS, 32'h01);
    reg_chk("info owed", sfe_pkg::ADDR_INFO, 32'h0801);
    $display("test chain done");
    // Reply frame followed by the terminator the block adds
    wait_rx(2);
    repeat (300) @(posedge clk_sys);
    chk("rsp ch", i_host.rx_q[0], 32'h52);
    chk("rsp lf", i_host.rx_q[1], 32'(sfe_pkg::CH_LF));
    chk("rsp frames", i_host.rx_bad, 32'h0);
    reg_chk("status rsp", sfe_pkg::ADDR_STATUS, 32'h11);
    reg_chk("info done", sfe_pkg::ADDR_INFO, 32'h0800);
    chk("ready done", rsp_ready, 32'h0);
    chk("no extra tx", i_host.rx_q.size(), 32'h2);
    $display("test response done");
    test_done();
  end
endmodule : test_serial_message_front_end
